// >>> shared/prc_pkg.sv
`default_nettype none
package prc_pkg;
    localparam logic [7:0] ADDR_BUF_IRQ_EN = 8'h0c;
    localparam logic [7:0] ADDR_CPU_IRQ_EN = 8'h0b;
    localparam logic [7:0] ADDR_REVISION = 8'h10;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h11;
    localparam logic [7:0] ADDR_POWER_CTRL = 8'h12;
    localparam logic [7:0] ADDR_SETTLE_HI = 8'h14;
    localparam logic [7:0] ADDR_SETTLE_LO = 8'h15;

    localparam logic [7:0] BUF_IRQ_EN_RESET = 8'h00;
    localparam logic [7:0] BUF_IRQ_EN_MASK = 8'h87;
    localparam logic [7:0] CPU_IRQ_EN_RESET = 8'h00;
    localparam logic [7:0] CPU_IRQ_EN_MASK = 8'h83;
    localparam logic [7:0] SOFT_RESET_RESET = 8'h80;
    localparam logic [15:0] SETTLE_RESET = 16'h0000;

    localparam int BIT_XCVR_RESET = 7;
    localparam int BIT_WHOLE_RESET = 0;
    localparam int BIT_REQ_SLEEP = 7;
    localparam int BIT_REQ_WAKE = 6;
    localparam int BIT_REQ_CUTOFF = 5;

    // top status bit positions
    localparam int TOP_BIT_CPU = 5;
    localparam int TOP_BIT_BUF = 4;
    localparam int TOP_BIT_DONE = 0;

    localparam logic [1:0] PSTATE_SLEEP = 2'b00;
    localparam logic [1:0] PSTATE_OSC_ONLY = 2'b01;
    localparam logic [1:0] PSTATE_ACTIVE = 2'b11;

    localparam int CLOCK_HZ = 50_000_000;
    localparam int PLL_SETTLE_US = 250;
    localparam int PLL_SETTLE_CYCLES = (PLL_SETTLE_US * (CLOCK_HZ / 1_000_000));
    localparam int STOP_STEP_CYCLES = 1;
endpackage
`default_nettype wire

// >>> shared/prc_clk_if.sv
`default_nettype none
interface prc_clk_if;
    logic osc_start;
    logic [15:0] settle_count;
    logic osc_ready;
    logic pll_start;
    logic pll_ready;
    logic stop_all;
    modport ctrl (output osc_start, output settle_count, output pll_start, output stop_all,
        input osc_ready, input pll_ready);
    modport timer (input osc_start, input settle_count, input pll_start, input stop_all,
        output osc_ready, output pll_ready);
endinterface
`default_nettype wire

// >>> design/prc_settle_timer.sv
`default_nettype none
module prc_settle_timer #(
    parameter int PLL_CYCLES = prc_pkg::PLL_SETTLE_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    prc_clk_if.timer bus
);
    typedef struct packed {
        logic [15:0] osc_cnt;
        logic osc_run;
        logic osc_ready;
        logic [31:0] pll_cnt;
        logic pll_run;
        logic pll_ready;
    } prc_tmr_t;
    prc_tmr_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (bus.stop_all) begin
            s_d = '0;
        end else begin
            // oscillator settle down-counter, gate opens at zero
            if (bus.osc_start && !s_q.osc_run && !s_q.osc_ready) begin
                s_d.osc_cnt = bus.settle_count;
                s_d.osc_run = 1'b1;
            end else if (s_q.osc_run) begin
                if (s_q.osc_cnt == 16'h0000) begin
                    s_d.osc_run = 1'b0;
                    s_d.osc_ready = 1'b1;
                end else begin
                    s_d.osc_cnt = s_q.osc_cnt - 16'h0001;
                end
            end
            if (bus.pll_start && !s_q.pll_run && !s_q.pll_ready) begin
                s_d.pll_cnt = 32'(PLL_CYCLES - 1);
                s_d.pll_run = 1'b1;
            end else if (s_q.pll_run) begin
                if (s_q.pll_cnt == 32'h0000_0000) begin
                    s_d.pll_run = 1'b0;
                    s_d.pll_ready = 1'b1;
                end else begin
                    s_d.pll_cnt = s_q.pll_cnt - 32'h0000_0001;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.osc_ready = s_q.osc_ready;
    assign bus.pll_ready = s_q.pll_ready;
endmodule
`default_nettype wire

// >>> design/prc_power_ctrl.sv
`default_nettype none
module prc_power_ctrl #(
    parameter int PLL_CYCLES = prc_pkg::PLL_SETTLE_CYCLES,
    parameter logic [7:0] REVISION = 8'h5a // arbitrary value
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_chip_select_n,
    input wire logic i_wr_strobe,
    input wire logic i_rd_strobe,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_processor_event_status,
    input wire logic [7:0] i_buffer_event_status,
    input wire logic [7:0] i_main_enable,
    input wire logic [7:0] i_top_irq_other,
    input wire logic i_top_done_clear,
    output logic [7:0] o_rdata,
    output logic [7:0] o_top_irq_status,
    output logic o_irq_out_n,
    output logic o_transceiver_reset,
    output logic o_whole_chip_reset,
    output logic o_input_cutoff,
    output logic o_osc_enable,
    output logic o_pll_enable,
    output logic [1:0] o_power_state
);
    typedef enum logic [5:0] {
        ST_ACTIVE = 6'b00_0001,
        ST_STOP_PLL = 6'b00_0010,
        ST_STOP_OSC = 6'b00_0100,
        ST_SLEEP = 6'b00_1000,
        ST_OSC_WAIT = 6'b01_0000,
        ST_PLL_WAIT = 6'b10_0000
    } prc_state_t;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [7:0] buf_en;
        logic [7:0] cpu_en;
        logic xcvr_rst;
        logic whole_rst;
        logic req_sleep;
        logic req_wake;
        logic cutoff;
        logic [15:0] settle;
        prc_state_t state;
        logic done_flag;
        logic [7:0] rdata;
        logic [7:0] top;
        logic irq_n;
        logic osc_en;
        logic pll_en;
        logic [1:0] pstate;
    } prc_ctl_t;

    prc_ctl_t s_q, s_d;
    logic rst_int_b;
    logic soft_b;
    logic wr;
    logic rd;
    prc_clk_if clk_bus();

    function automatic logic [1:0] state_code(input prc_state_t st);
        unique case (st)
            ST_ACTIVE, ST_STOP_PLL: state_code = prc_pkg::PSTATE_ACTIVE;
            ST_STOP_OSC, ST_OSC_WAIT, ST_PLL_WAIT: state_code = prc_pkg::PSTATE_OSC_ONLY;
            ST_SLEEP: state_code = prc_pkg::PSTATE_SLEEP;
            default: state_code = prc_pkg::PSTATE_ACTIVE;
        endcase
    endfunction

    // reset sync lives in its own flops so the soft reset cannot clear it
    logic [1:0] sync_q;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_q <= 2'b00;
        end else begin
            sync_q <= {sync_q[0], 1'b1};
        end
    end
    assign rst_int_b = sync_q[1];
    // the soft reset pulse clears logic without replaying the power-on period
    assign soft_b = !s_q.whole_rst;

    // accesses during sleep still decode; during cutoff only reads decode, so the cutoff-clearing read stays reachable
    assign wr = !i_chip_select_n && i_wr_strobe && !s_q.cutoff;
    assign rd = !i_chip_select_n && i_rd_strobe;

    assign clk_bus.osc_start = (s_q.state == ST_OSC_WAIT);
    assign clk_bus.settle_count = s_q.settle;
    assign clk_bus.pll_start = (s_q.state == ST_PLL_WAIT);
    assign clk_bus.stop_all = (s_q.state == ST_SLEEP) || !soft_b;

    prc_settle_timer #(.PLL_CYCLES(PLL_CYCLES)) u_timer (
        .i_clock(i_clock),
        .i_rst_b(rst_int_b),
        .bus(clk_bus)
    );

    always_comb begin
        s_d = s_q;
        // only the second synchroniser flop is read
        s_d.rst_sync = {sync_q[1], sync_q[1]};
        s_d.whole_rst = 1'b0;
        if (wr) begin
            unique case (i_addr)
                prc_pkg::ADDR_BUF_IRQ_EN: s_d.buf_en = i_wdata & prc_pkg::BUF_IRQ_EN_MASK;
                prc_pkg::ADDR_CPU_IRQ_EN: s_d.cpu_en = i_wdata & prc_pkg::CPU_IRQ_EN_MASK;
                prc_pkg::ADDR_SOFT_RESET: begin
                    s_d.xcvr_rst = i_wdata[prc_pkg::BIT_XCVR_RESET];
                    s_d.whole_rst = i_wdata[prc_pkg::BIT_WHOLE_RESET];
                end
                prc_pkg::ADDR_POWER_CTRL: begin
                    if (i_wdata[prc_pkg::BIT_REQ_SLEEP] && s_q.state == ST_ACTIVE) begin
                        s_d.req_sleep = 1'b1;
                    end
                    if (i_wdata[prc_pkg::BIT_REQ_WAKE] && s_q.state == ST_SLEEP) begin
                        s_d.req_wake = 1'b1;
                    end
                    if (i_wdata[prc_pkg::BIT_REQ_CUTOFF] && s_q.state == ST_SLEEP) begin
                        s_d.cutoff = 1'b1;
                    end
                end
                prc_pkg::ADDR_SETTLE_HI: s_d.settle[15:8] = i_wdata;
                prc_pkg::ADDR_SETTLE_LO: s_d.settle[7:0] = i_wdata;
                default: ;
            endcase
        end
        if (rd && i_addr == prc_pkg::ADDR_POWER_CTRL && s_q.cutoff) begin
            s_d.cutoff = 1'b0;
        end

        s_d.done_flag = s_q.done_flag && !i_top_done_clear;
        unique case (s_q.state)
            ST_ACTIVE: begin
                if (s_q.req_sleep) begin
                    s_d.state = ST_STOP_PLL;
                end
            end
            ST_STOP_PLL: begin
                s_d.pll_en = 1'b0;
                s_d.state = ST_STOP_OSC;
            end
            ST_STOP_OSC: begin
                s_d.osc_en = 1'b0;
                s_d.state = ST_SLEEP;
                s_d.req_sleep = 1'b0;
                s_d.done_flag = 1'b1;
            end
            ST_SLEEP: begin
                if (s_q.req_wake) begin
                    s_d.osc_en = 1'b1;
                    s_d.state = ST_OSC_WAIT;
                end
            end
            ST_OSC_WAIT: begin
                if (clk_bus.osc_ready) begin
                    s_d.pll_en = 1'b1;
                    s_d.state = ST_PLL_WAIT;
                end
            end
            ST_PLL_WAIT: begin
                if (clk_bus.pll_ready) begin
                    s_d.state = ST_ACTIVE;
                    s_d.req_wake = 1'b0;
                    s_d.done_flag = 1'b1;
                end
            end
            default: s_d.state = ST_ACTIVE;
        endcase
        s_d.pstate = state_code(s_d.state);

        s_d.top = i_top_irq_other;
        s_d.top[prc_pkg::TOP_BIT_CPU] = |(i_processor_event_status & s_q.cpu_en);
        s_d.top[prc_pkg::TOP_BIT_BUF] = |(i_buffer_event_status & s_q.buf_en);
        s_d.top[prc_pkg::TOP_BIT_DONE] = s_d.done_flag;
        s_d.irq_n = !(|(s_d.top & i_main_enable));

        s_d.rdata = 8'h00;
        if (rd) begin
            unique case (i_addr)
                prc_pkg::ADDR_BUF_IRQ_EN: s_d.rdata = s_q.buf_en;
                prc_pkg::ADDR_CPU_IRQ_EN: s_d.rdata = s_q.cpu_en;
                prc_pkg::ADDR_REVISION: s_d.rdata = REVISION;
                prc_pkg::ADDR_SOFT_RESET: s_d.rdata = {s_q.xcvr_rst, 7'h00};
                prc_pkg::ADDR_POWER_CTRL: begin
                    s_d.rdata = {s_q.req_sleep, s_q.req_wake, 4'h0,
                        state_code(s_q.state)};
                end
                prc_pkg::ADDR_SETTLE_HI: s_d.rdata = s_q.settle[15:8];
                prc_pkg::ADDR_SETTLE_LO: s_d.rdata = s_q.settle[7:0];
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge rst_int_b) begin
        if (!rst_int_b) begin
            s_q.rst_sync <= 2'b00;
            s_q.buf_en <= prc_pkg::BUF_IRQ_EN_RESET;
            s_q.cpu_en <= prc_pkg::CPU_IRQ_EN_RESET;
            s_q.xcvr_rst <= prc_pkg::SOFT_RESET_RESET[prc_pkg::BIT_XCVR_RESET];
            s_q.whole_rst <= 1'b0;
            s_q.req_sleep <= 1'b0;
            s_q.req_wake <= 1'b0;
            s_q.cutoff <= 1'b0;
            s_q.settle <= prc_pkg::SETTLE_RESET;
            s_q.state <= ST_ACTIVE;
            s_q.done_flag <= 1'b0;
            s_q.rdata <= 8'h00;
            s_q.top <= 8'h00;
            s_q.irq_n <= 1'b1;
            s_q.osc_en <= 1'b1;
            s_q.pll_en <= 1'b1;
            s_q.pstate <= prc_pkg::PSTATE_ACTIVE;
        end else if (!soft_b) begin
            // whole-chip soft reset: same values except rst_sync, host bus config lives outside this block
            s_q <= '0;
            s_q.rst_sync <= s_d.rst_sync;
            s_q.xcvr_rst <= 1'b1;
            s_q.state <= ST_ACTIVE;
            s_q.irq_n <= 1'b1;
            s_q.osc_en <= 1'b1;
            s_q.pll_en <= 1'b1;
            s_q.pstate <= prc_pkg::PSTATE_ACTIVE;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;
    assign o_top_irq_status = s_q.top;
    assign o_irq_out_n = s_q.irq_n;
    assign o_transceiver_reset = s_q.xcvr_rst;
    assign o_whole_chip_reset = s_q.whole_rst;
    assign o_input_cutoff = s_q.cutoff;
    assign o_osc_enable = s_q.osc_en;
    assign o_pll_enable = s_q.pll_en;
    assign o_power_state = s_q.pstate;
endmodule
`default_nettype wire

// >>> test/prc_power_chk_sva.sv
`default_nettype none
module prc_power_chk (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_chip_select_n,
    input wire logic i_rd_strobe,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_processor_event_status,
    input wire logic [7:0] i_buffer_event_status,
    input wire logic [7:0] i_main_enable,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] o_top_irq_status,
    input wire logic o_irq_out_n,
    input wire logic o_transceiver_reset,
    input wire logic o_whole_chip_reset,
    input wire logic o_input_cutoff,
    input wire logic o_osc_enable,
    input wire logic o_pll_enable,
    input wire logic [1:0] o_power_state
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    // three quiet cycles cover the registered summary path
    property p_cpu_sum; (i_processor_event_status == 8'h00) [*3] |-> !o_top_irq_status[5]; endproperty
    a_cpu_sum: assert property (p_cpu_sum) else $error("cpu summary without event");
    property p_buf_sum; (i_buffer_event_status == 8'h00) [*3] |-> !o_top_irq_status[4]; endproperty
    a_buf_sum: assert property (p_buf_sum) else $error("buffer summary without event");
    property p_irq_mask; (i_main_enable == 8'h00) [*3] |-> o_irq_out_n; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq out while all masked");
    property p_state_code; o_power_state != 2'b10; endproperty
    a_state_code: assert property (p_state_code) else $error("illegal power state");
    // soft reset raises both clocks at once, so it is excluded from the order checks
    property p_pll_first; ($fell(o_osc_enable) && !$past(o_whole_chip_reset)) |-> $past(o_pll_enable) == 1'b0; endproperty
    a_pll_first: assert property (p_pll_first) else $error("osc stopped before pll");
    property p_osc_first; ($rose(o_pll_enable) && !$past(o_whole_chip_reset)) |-> $past(o_osc_enable) && o_power_state == prc_pkg::PSTATE_OSC_ONLY; endproperty
    a_osc_first: assert property (p_osc_first) else $error("pll started without osc");
    property p_done; ($changed(o_power_state) && o_power_state != prc_pkg::PSTATE_OSC_ONLY && !$past(o_whole_chip_reset)) |-> ##[0:1] o_top_irq_status[0]; endproperty
    a_done: assert property (p_done) else $error("transition done not flagged");
    property p_soft_xcvr; $rose(o_whole_chip_reset) |-> ##[1:2] o_transceiver_reset; endproperty
    a_soft_xcvr: assert property (p_soft_xcvr) else $error("soft reset left xcvr free");
    property p_cut_exit; (o_input_cutoff && !i_chip_select_n && i_rd_strobe && i_addr == prc_pkg::ADDR_POWER_CTRL) |-> ##[1:2] !o_input_cutoff; endproperty
    a_cut_exit: assert property (p_cut_exit) else $error("cutoff kept after read");
    property p_rdata_idle; !$past(i_rd_strobe) |-> o_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
endmodule
bind prc_power_ctrl prc_power_chk u_chk (.*);
`default_nettype wire

// >>> test/prc_host_model.sv
`default_nettype none
module prc_host_model (
    input wire logic i_clock,
    input wire logic [7:0] i_rdata,
    output logic o_cs_n,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_cs_n = 1'b1;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic access(input logic [7:0] a, d, input logic w, output logic [7:0] q);
        @(posedge i_clock);
        o_cs_n <= 1'b0;
        o_wr <= w;
        o_rd <= !w;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clock);
        o_cs_n <= 1'b1;
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        // released lines show a changed value, never the last one
        o_addr <= ~a;
        o_wdata <= ~d;
        @(posedge i_clock);
        q = i_rdata;
    endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] REV = 8'h3c; // arbitrary value
    localparam logic [7:0] EN = 8'h87;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_chip_select_n, i_wr_strobe, i_rd_strobe, i_top_done_clear = 1'b0;
    logic [7:0] i_addr, i_wdata, i_processor_event_status = 8'h00, i_buffer_event_status = 8'h00;
    logic [7:0] i_main_enable = 8'h00, i_top_irq_other = 8'h00, o_rdata, o_top_irq_status;
    logic o_irq_out_n, o_transceiver_reset, o_whole_chip_reset, o_input_cutoff;
    logic o_osc_enable, o_pll_enable;
    logic [1:0] o_power_state;
    int error_cnt = 0;
    int n_checks = 0;
    always #10 i_clock = ~i_clock;
    prc_host_model i_host (.i_clock(i_clock), .i_rdata(o_rdata), .o_cs_n(i_chip_select_n),
        .o_wr(i_wr_strobe), .o_rd(i_rd_strobe), .o_addr(i_addr), .o_wdata(i_wdata));
    prc_power_ctrl #(.PLL_CYCLES(8), .REVISION(REV)) i_dut (.*);
    task automatic ck(input logic [7:0] g, e, input string m);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        i_host.access(a, d, 1'b1, q);
    endtask
    task automatic rd(input logic [7:0] a, e, input string m);
        logic [7:0] q;
        i_host.access(a, 8'h00, 1'b0, q);
        ck(q, e, m);
    endtask
    task automatic t_reset;
        rd(prc_pkg::ADDR_BUF_IRQ_EN, 8'h00, "buf en reset");
        rd(prc_pkg::ADDR_SOFT_RESET, 8'h80, "reset reg");
        rd(prc_pkg::ADDR_POWER_CTRL, 8'h03, "pm reset");
        rd(prc_pkg::ADDR_REVISION, REV, "revision");
        rd(8'h30, 8'h00, "unmapped");
    endtask
    task automatic t_gate;
        wr(prc_pkg::ADDR_BUF_IRQ_EN, 8'hff);
        rd(prc_pkg::ADDR_BUF_IRQ_EN, EN, "buf en mask");
        i_main_enable <= 8'h10;
        for (int i = 0; i < 8; i++) begin
            i_buffer_event_status <= 8'h01 << i;
            tick(4);
            ck({7'h0, o_top_irq_status[4]}, {7'h0, EN[i]}, "buf summary");
            ck({7'h0, o_irq_out_n}, {7'h0, !EN[i]}, "irq out");
        end
        i_main_enable <= 8'h00;
        tick(4);
        ck({7'h0, o_irq_out_n}, 8'h01, "irq masked");
        i_buffer_event_status <= 8'h00;
        wr(prc_pkg::ADDR_CPU_IRQ_EN, 8'h01);
        i_processor_event_status <= 8'h01;
        tick(4);
        ck({7'h0, o_top_irq_status[5]}, 8'h01, "cpu summary on");
        i_processor_event_status <= 8'h02;
        tick(4);
        ck({7'h0, o_top_irq_status[5]}, 8'h00, "cpu summary off");
        i_processor_event_status <= 8'h00;
    endtask
    task automatic t_xcvr;
        ck({7'h0, o_transceiver_reset}, 8'h01, "xcvr held");
        wr(prc_pkg::ADDR_SOFT_RESET, 8'h00);
        ck({7'h0, o_transceiver_reset}, 8'h00, "xcvr free");
        rd(prc_pkg::ADDR_SOFT_RESET, 8'h00, "reset reg clear");
    endtask
    task automatic t_sleep;
        int n;
        n = 0;
        wr(prc_pkg::ADDR_POWER_CTRL, 8'h80);
        while (o_power_state !== prc_pkg::PSTATE_SLEEP && n < 50) begin
            tick(1);
            n++;
        end
        tick(2);
        ck({5'h0, o_osc_enable, o_power_state}, 8'h00, "sleep state");
        ck({7'h0, o_top_irq_status[0]}, 8'h01, "sleep done");
        rd(prc_pkg::ADDR_POWER_CTRL, 8'h00, "sleep req clear");
        rd(prc_pkg::ADDR_REVISION, REV, "revision asleep");
        i_top_done_clear <= 1'b1;
        tick(1);
        i_top_done_clear <= 1'b0;
        tick(2);
        ck({7'h0, o_top_irq_status[0]}, 8'h00, "done cleared");
        wr(prc_pkg::ADDR_POWER_CTRL, 8'h20);
        ck({7'h0, o_input_cutoff}, 8'h01, "cutoff on");
        rd(prc_pkg::ADDR_POWER_CTRL, 8'h00, "dummy read");
        tick(1);
        ck({7'h0, o_input_cutoff}, 8'h00, "cutoff off");
    endtask
    task automatic t_wake;
        int n, a, b;
        n = 0;
        a = 0;
        b = 0;
        wr(prc_pkg::ADDR_SETTLE_HI, 8'h00);
        wr(prc_pkg::ADDR_SETTLE_LO, 8'h10);
        wr(prc_pkg::ADDR_POWER_CTRL, 8'h40);
        while (o_power_state !== prc_pkg::PSTATE_ACTIVE && n < 500) begin
            tick(1);
            n++;
            a += (o_osc_enable === 1'b1 && o_pll_enable === 1'b0);
            b += (o_pll_enable === 1'b1);
        end
        // load, count-out and gate hand-off add three cycles to the osc settle count and two to PLL_CYCLES
        ck({7'h0, a >= 17 && a <= 19}, 8'h01, "settle count");
        ck({7'h0, b >= 9 && b <= 11}, 8'h01, "pll wait");
        tick(2);
        ck({7'h0, o_top_irq_status[0]}, 8'h01, "wake done");
        rd(prc_pkg::ADDR_POWER_CTRL, 8'h03, "wake req clear");
    endtask
    task automatic t_soft;
        wr(prc_pkg::ADDR_BUF_IRQ_EN, 8'h87);
        wr(prc_pkg::ADDR_SOFT_RESET, 8'h01);
        ck({7'h0, o_whole_chip_reset}, 8'h01, "soft pulse");
        tick(2);
        ck({7'h0, o_transceiver_reset}, 8'h01, "xcvr re-held");
        rd(prc_pkg::ADDR_BUF_IRQ_EN, 8'h00, "soft cleared");
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100_000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        tick(6);
        i_rst_b <= 1'b1;
        tick(3);
        t_reset;
        t_gate;
        t_xcvr;
        t_sleep;
        t_wake;
        t_soft;
        print_verdict;
    end
endmodule
`default_nettype wire
